// file: ocu_cfg.svh
// Constants of the timer output compare unit.
// Assumes inclusion by the package and by the unit itself.
`ifndef OCU_CFG_SVH
`define OCU_CFG_SVH

// Channel count and widths
`define OCU_NCH 3
`define OCU_CW 16
`define OCU_DW 8
`define OCU_AW 5

// Register byte offsets
`define OCU_ADDR_ACTION 5'h00
`define OCU_ADDR_MODE 5'h01
`define OCU_ADDR_FORCE 5'h02
`define OCU_ADDR_IRQ_EN 5'h03
`define OCU_ADDR_FLAGS 5'h04
`define OCU_ADDR_STATE 5'h05
`define OCU_ADDR_CMP_BASE 5'h08

// Field positions
`define OCU_ACTION_LSB(ch) (6 - 2 * (ch))
`define OCU_MODE_W 4

// Reset values
`define OCU_RST_BYTE 8'h00
`define OCU_RST_WORD 16'h0000
`define OCU_RST_MODE 4'h0
`define OCU_RST_ACTION 2'h0

// Waveform modes
`define OCU_WGM_NORMAL 4'h0
`define OCU_WGM_PC8 4'h1
`define OCU_WGM_PC9 4'h2
`define OCU_WGM_PC10 4'h3
`define OCU_WGM_CTC_A 4'h4
`define OCU_WGM_FAST8 4'h5
`define OCU_WGM_FAST9 4'h6
`define OCU_WGM_FAST10 4'h7
`define OCU_WGM_PFC_CAP 4'h8
`define OCU_WGM_PFC_A 4'h9
`define OCU_WGM_PC_CAP 4'hA
`define OCU_WGM_PC_A 4'hB
`define OCU_WGM_CTC_CAP 4'hC
`define OCU_WGM_RESERVED 4'hD
`define OCU_WGM_FAST_CAP 4'hE
`define OCU_WGM_FAST_A 4'hF

// Output actions
`define OCU_ACT_NONE 2'h0
`define OCU_ACT_TOGGLE 2'h1
`define OCU_ACT_CLEAR 2'h2
`define OCU_ACT_SET 2'h3

`endif

// file: ocu_pkg.sv
// Types of the timer output compare unit.
// Assumes ocu_cfg.svh is on the include path.
`include "ocu_cfg.svh"

package ocu_pkg;

  typedef logic [`OCU_CW-1:0] word_t;
  typedef logic [`OCU_DW-1:0] byte_t;
  typedef logic [`OCU_NCH-1:0] chmask_t;

  // Register port request
  typedef struct packed {
    logic [`OCU_AW-1:0] addr;
    byte_t wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Counter status from the timer core
  typedef struct packed {
    word_t value;
    logic tick;
    logic top;
    logic bottom;
    logic count_down;
    logic written;
  } cnt_status_t;

  // Whole unit state
  typedef struct packed {
    word_t [`OCU_NCH-1:0] cmp;
    word_t [`OCU_NCH-1:0] buffer;
    byte_t latch;
    logic [`OCU_NCH-1:0][1:0] action;
    logic [`OCU_MODE_W-1:0] mode;
    chmask_t irq_en;
    chmask_t flag;
    chmask_t pend;
    chmask_t state;
    logic block;
    byte_t rdata;
  } ocu_state_t;

endpackage

// file: ocu_compare_unit.sv
// Output compare channels of a 16-bit timer, with 8-bit register port.
// Assumes counter sequencing and prescaling live in the timer core, same clock.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "ocu_cfg.svh"

module ocu_compare_unit
  import ocu_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire bus_req_t bus_req,
  output byte_t bus_rdata,
  input wire cnt_status_t cnt,
  input wire chmask_t irq_ack,
  output chmask_t irq_req,
  output word_t top_from_a,
  output logic a_defines_top,
  input wire chmask_t port_data,
  input wire chmask_t pin_direction_bit,
  output chmask_t pin_out,
  output chmask_t pin_oe
);

  // ********************************************************
  // Mode decoding
  // ********************************************************

  function automatic logic is_pwm(input logic [`OCU_MODE_W-1:0] m);
    is_pwm = !(m == `OCU_WGM_NORMAL || m == `OCU_WGM_CTC_A ||
               m == `OCU_WGM_CTC_CAP || m == `OCU_WGM_RESERVED);
  endfunction

  function automatic logic is_fast(input logic [`OCU_MODE_W-1:0] m);
    is_fast = (m == `OCU_WGM_FAST8 || m == `OCU_WGM_FAST9 || m == `OCU_WGM_FAST10 ||
               m == `OCU_WGM_FAST_CAP || m == `OCU_WGM_FAST_A);
  endfunction

  function automatic logic loads_at_bottom(input logic [`OCU_MODE_W-1:0] m);
    loads_at_bottom = (m == `OCU_WGM_PFC_CAP || m == `OCU_WGM_PFC_A);
  endfunction

  // Non-PWM action applied on match or force
  function automatic logic plain_action(input logic [1:0] act, input logic cur);
    case (act)
      `OCU_ACT_TOGGLE: plain_action = !cur;
      `OCU_ACT_CLEAR: plain_action = 1'b0;
      `OCU_ACT_SET: plain_action = 1'b1;
      default: plain_action = cur;
    endcase
  endfunction

  // ********************************************************
  // State
  // ********************************************************

  ocu_state_t st_r;
  ocu_state_t st_nxt;
  logic pwm;
  logic db_on;
  logic load_pt;
  logic [`OCU_NCH-1:0] match;
  logic [`OCU_AW-1:0] cmp_off;
  logic [`OCU_AW-1:0] ch_idx;
  logic cmp_hit;
  word_t cpu_word;

  assign pwm = is_pwm(st_r.mode);
  assign db_on = pwm;
  assign load_pt = cnt.tick && (loads_at_bottom(st_r.mode) ? cnt.bottom : cnt.top);

  always_comb begin
    for (int c = 0; c < `OCU_NCH; c++) begin
      match[c] = cnt.tick && !st_r.block && (cnt.value == st_r.cmp[c]);
    end
  end

  assign cmp_off = bus_req.addr - `OCU_ADDR_CMP_BASE;
  assign ch_idx = {1'b0, cmp_off[`OCU_AW-1:1]};
  assign cmp_hit = (bus_req.addr >= `OCU_ADDR_CMP_BASE) && (ch_idx < `OCU_AW'(`OCU_NCH));
  assign cpu_word = db_on ? st_r.buffer[ch_idx] : st_r.cmp[ch_idx];

  always_comb begin
    st_nxt = st_r;
    // Match blocking lasts until the next tick, even if stopped
    if (cnt.written) begin
      st_nxt.block = 1'b1;
    end else if (cnt.tick) begin
      st_nxt.block = 1'b0;
    end

    // ********************************************************
    // Compare registers and double buffer
    // ********************************************************
    for (int c = 0; c < `OCU_NCH; c++) begin
      if (!db_on) begin
        st_nxt.buffer[c] = st_r.cmp[c];
      end else if (load_pt) begin
        st_nxt.cmp[c] = st_r.buffer[c];
      end
    end

    // ********************************************************
    // Flags and output state
    // ********************************************************
    for (int c = 0; c < `OCU_NCH; c++) begin
      if (cnt.tick) begin
        st_nxt.pend[c] = match[c];
      end
      if (irq_ack[c]) begin
        st_nxt.flag[c] = 1'b0;
      end
      if (st_r.action[c] != `OCU_ACT_NONE) begin
        if (!pwm) begin
          if (match[c]) begin
            st_nxt.state[c] = plain_action(st_r.action[c], st_r.state[c]);
          end
        end else if (is_fast(st_r.mode)) begin
          if (st_r.action[c][1] && cnt.tick && cnt.top) begin
            st_nxt.state[c] = st_r.action[c][0];
          end else if (st_r.action[c][1] && match[c]) begin
            st_nxt.state[c] = !st_r.action[c][0];
          end
        end else if (st_r.action[c][1] && match[c]) begin
          // Dual slope: level depends on direction, inverted by low bit
          st_nxt.state[c] = cnt.count_down ^ st_r.action[c][0];
        end
      end
    end

    // ********************************************************
    // Register writes
    // ********************************************************
    st_nxt.rdata = `OCU_RST_BYTE;
    if (bus_req.wr) begin
      case (bus_req.addr)
        `OCU_ADDR_ACTION: begin
          for (int c = 0; c < `OCU_NCH; c++) begin
            st_nxt.action[c] = bus_req.wdata[`OCU_ACTION_LSB(c) +: 2];
          end
        end
        `OCU_ADDR_MODE: begin
          st_nxt.mode = bus_req.wdata[`OCU_MODE_W-1:0];
        end
        `OCU_ADDR_FORCE: begin
          if (!pwm) begin
            for (int c = 0; c < `OCU_NCH; c++) begin
              if (bus_req.wdata[c]) begin
                st_nxt.state[c] = plain_action(st_r.action[c], st_r.state[c]);
              end
            end
          end
        end
        `OCU_ADDR_IRQ_EN: begin
          st_nxt.irq_en = bus_req.wdata[`OCU_NCH-1:0];
        end
        `OCU_ADDR_FLAGS: begin
          st_nxt.flag = st_nxt.flag & ~bus_req.wdata[`OCU_NCH-1:0];
        end
        default: begin
          if (cmp_hit) begin
            if (cmp_off[0]) begin
              st_nxt.latch = bus_req.wdata;
            end else if (db_on) begin
              st_nxt.buffer[ch_idx] = {st_r.latch, bus_req.wdata};
            end else begin
              st_nxt.cmp[ch_idx] = {st_r.latch, bus_req.wdata};
              st_nxt.buffer[ch_idx] = {st_r.latch, bus_req.wdata};
            end
          end
        end
      endcase
    end

    // Hardware set wins over any clear in the same cycle
    for (int c = 0; c < `OCU_NCH; c++) begin
      if (cnt.tick && st_r.pend[c]) begin
        st_nxt.flag[c] = 1'b1;
      end
    end

    // ********************************************************
    // Register reads
    // ********************************************************
    if (bus_req.rd) begin
      case (bus_req.addr)
        `OCU_ADDR_ACTION: begin
          for (int c = 0; c < `OCU_NCH; c++) begin
            st_nxt.rdata[`OCU_ACTION_LSB(c) +: 2] = st_r.action[c];
          end
        end
        `OCU_ADDR_MODE: st_nxt.rdata[`OCU_MODE_W-1:0] = st_r.mode;
        `OCU_ADDR_IRQ_EN: st_nxt.rdata[`OCU_NCH-1:0] = st_r.irq_en;
        `OCU_ADDR_FLAGS: st_nxt.rdata[`OCU_NCH-1:0] = st_r.flag;
        `OCU_ADDR_STATE: st_nxt.rdata[`OCU_NCH-1:0] = st_r.state;
        default: begin
          // Force register reads as zero here too
          if (cmp_hit) begin
            if (cmp_off[0]) begin
              st_nxt.rdata = cpu_word[`OCU_CW-1:`OCU_DW];
            end else begin
              st_nxt.rdata = cpu_word[`OCU_DW-1:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************

  assign bus_rdata = st_r.rdata;
  assign irq_req = st_r.flag & st_r.irq_en;
  assign top_from_a = st_r.cmp[0];
  assign a_defines_top = (st_r.mode == `OCU_WGM_CTC_A || st_r.mode == `OCU_WGM_PFC_A ||
                          st_r.mode == `OCU_WGM_PC_A || st_r.mode == `OCU_WGM_FAST_A);

  always_comb begin
    for (int c = 0; c < `OCU_NCH; c++) begin
      pin_out[c] = (st_r.action[c] != `OCU_ACT_NONE) ? st_r.state[c] : port_data[c];
    end
  end

  assign pin_oe = pin_direction_bit;

endmodule

// file: ocu_compare_unit_props.sv
// Port checker for the output compare unit.
// Assumes binding into ocu_compare_unit; channel A only, except the pin enable check, which covers all channels.
`timescale 1ns/1ns
module ocu_compare_unit_chk
  import ocu_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire bus_req_t bus_req,
  input wire byte_t bus_rdata,
  input wire cnt_status_t cnt,
  input wire chmask_t irq_ack,
  input wire chmask_t irq_req,
  input wire word_t top_from_a,
  input wire logic a_defines_top,
  input wire chmask_t port_data,
  input wire chmask_t pin_direction_bit,
  input wire chmask_t pin_out,
  input wire chmask_t pin_oe
);
  byte_t hi_r;
  logic [3:0] mode_r;
  logic [1:0] act_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_r <= 8'h00;
      mode_r <= 4'h0;
      act_r <= 2'h0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == 5'h09) hi_r <= bus_req.wdata;
      if (bus_req.addr == 5'h01) mode_r <= bus_req.wdata[3:0];
      if (bus_req.addr == 5'h00) act_r <= bus_req.wdata[7:6];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_oe_dir: assert property (pin_oe == pin_direction_bit) else $error("pin enable not direction");
  a_port_pass: assert property (act_r == 2'h0 |-> pin_out[0] == port_data[0])
    else $error("pin A not port data");
  a_force_zero: assert property (bus_req.rd && bus_req.addr == 5'h02 |=> bus_rdata == 8'h00)
    else $error("force read not zero");
  a_ack_clear: assert property (irq_ack[0] && !cnt.tick |=> !irq_req[0]) else $error("ack kept request");
  a_w1c_clear: assert property (bus_req.wr && bus_req.addr == 5'h04 && bus_req.wdata[0] && !cnt.tick
    |=> !irq_req[0]) else $error("flag write kept request");
  a_top_select: assert property (bus_req.wr && bus_req.addr == 5'h01
    |=> a_defines_top == (mode_r inside {4'h4, 4'h9, 4'hB, 4'hF})) else $error("top source wrong");
  a_direct_load: assert property (bus_req.wr && bus_req.addr == 5'h08 && mode_r inside {4'h0, 4'h4, 4'hC}
    |=> top_from_a == {hi_r, $past(bus_req.wdata)}) else $error("direct load wrong");
  a_flag_on_tick: assert property ($rose(irq_req[0]) && !$past(bus_req.wr) |-> $past(cnt.tick))
    else $error("flag rose without tick");
  a_cmp_stable: assert property ($changed(top_from_a) |-> $past(bus_req.wr) || $past(cnt.tick))
    else $error("compare changed by itself");
endmodule

bind ocu_compare_unit ocu_compare_unit_chk chk (.clk(clk), .resetn(resetn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .cnt(cnt), .irq_ack(irq_ack), .irq_req(irq_req), .top_from_a(top_from_a),
  .a_defines_top(a_defines_top), .port_data(port_data), .pin_direction_bit(pin_direction_bit),
  .pin_out(pin_out), .pin_oe(pin_oe));

// file: pin_load.sv
// Model of the pins with external pull-ups.
// Assumes pin_out and pin_oe from the unit.
`timescale 1ns/1ns
module pin_load
  import ocu_pkg::*;
(
  input wire chmask_t pin_out,
  input wire chmask_t pin_oe,
  output chmask_t pin_level
);
  // Undriven pins float high
  assign pin_level = (pin_out & pin_oe) | ~pin_oe;
endmodule

// file: test_timer16_output_compare_unit.sv
// Testbench of the output compare unit, channel A, with channel B compare and flag in the last part.
// Assumes ocu_pkg and pin_load compiled first.
`timescale 1ns/1ns
module test_timer16_output_compare_unit;
  import ocu_pkg::*;
  typedef struct packed {logic [3:0] m; logic [1:0] a; logic s;} row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  bus_req_t bus_req = '0;
  cnt_status_t cnt = '0;
  chmask_t irq_ack = 3'h0;
  chmask_t dir = 3'h0;
  chmask_t port_data = 3'h2;
  byte_t bus_rdata;
  chmask_t irq_req, pin_out, pin_oe, pin_level;
  word_t top_from_a;
  logic a_defines_top;
  logic prev;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  row_t rows [7] = '{'{4'h0, 2'h3, 1'b1}, '{4'h0, 2'h0, 1'b1}, '{4'h4, 2'h1, 1'b0}, '{4'hC, 2'h1, 1'b1},
    '{4'h0, 2'h2, 1'b0}, '{4'hF, 2'h2, 1'b1}, '{4'h5, 2'h3, 1'b0}};
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
  always #2 clk = ~clk;
  ocu_compare_unit uut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata), .cnt(cnt),
    .irq_ack(irq_ack), .irq_req(irq_req), .top_from_a(top_from_a), .a_defines_top(a_defines_top),
    .port_data(port_data), .pin_direction_bit(dir), .pin_out(pin_out), .pin_oe(pin_oe));
  pin_load pl (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic wr(input logic [4:0] a, input byte_t d);
    @(posedge clk) bus_req <= {a, d, 2'b10};
    @(posedge clk) bus_req <= '0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input byte_t e);
    @(posedge clk) bus_req <= {a, 8'h00, 2'b01};
    @(posedge clk) bus_req <= '0;
    #1 `CHK("rdata", e, bus_rdata)
  endtask
  task automatic tk(input word_t v, input logic t);
    @(posedge clk) cnt <= {v, 1'b1, t, 3'b000};
    @(posedge clk) cnt <= '0;
    #1;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(5'h05, 8'h00);
    wr(5'h02, 8'h01);
    @(posedge clk) dir <= 3'h7;
    wr(5'h09, 8'h00);
    wr(5'h08, 8'h10);
    prev = 1'b0;
    for (int i = 0; i < 7; i++) begin
      wr(5'h01, {4'h0, rows[i].m});
      rd(5'h05, {7'h00, prev});
      wr(5'h00, {rows[i].a, 6'h00});
      tk(16'h0010, 1'b0);
      rd(5'h05, {7'h00, rows[i].s});
      `CHK("pin", (rows[i].a != 2'h0) ? rows[i].s : port_data[0], pin_level[0])
      prev = rows[i].s;
    end
    tk(16'h0000, 1'b1);
    rd(5'h05, 8'h01);
    $display("table done");
    wr(5'h03, 8'h01);
    wr(5'h04, 8'h07);
    wr(5'h01, 8'h00);
    tk(16'h0010, 1'b0);
    `CHK("irq", 1'b0, irq_req[0])
    tk(16'h0011, 1'b0);
    `CHK("irq", 1'b1, irq_req[0])
    @(posedge clk) irq_ack <= 3'h1;
    @(posedge clk) irq_ack <= 3'h0;
    #1 `CHK("irq", 1'b0, irq_req[0])
    tk(16'h0010, 1'b0);
    tk(16'h0011, 1'b0);
    wr(5'h04, 8'h00);
    `CHK("irq", 1'b1, irq_req[0])
    wr(5'h04, 8'h01);
    `CHK("irq", 1'b0, irq_req[0])
    @(posedge clk) cnt.written <= 1'b1;
    @(posedge clk) cnt.written <= 1'b0;
    tk(16'h0010, 1'b0);
    tk(16'h0011, 1'b0);
    `CHK("irq", 1'b0, irq_req[0])
    $display("flag done");
    wr(5'h00, 8'h40);
    wr(5'h02, 8'h01);
    rd(5'h05, 8'h00);
    rd(5'h02, 8'h00);
    wr(5'h01, 8'h0F);
    wr(5'h02, 8'h01);
    rd(5'h05, 8'h00);
    wr(5'h09, 8'h01);
    wr(5'h08, 8'h23);
    `CHK("top", 16'h0010, top_from_a)
    rd(5'h08, 8'h23);
    tk(16'h0005, 1'b1);
    `CHK("top", 16'h0123, top_from_a)
    wr(5'h01, 8'h00);
    wr(5'h09, 8'h77);
    `CHK("top", 16'h0123, top_from_a)
    rd(5'h09, 8'h01);
    wr(5'h08, 8'h55);
    `CHK("top", 16'h7755, top_from_a)
    wr(5'h1F, 8'hFF);
    `CHK("top", 16'h7755, top_from_a)
    rd(5'h1F, 8'h00);
    wr(5'h02, 8'h01);
    rd(5'h05, 8'h01);
    @(posedge clk) resetn <= 1'b0;
    @(posedge clk) resetn <= 1'b1;
    rd(5'h05, 8'h00);
    wr(5'h00, 8'h10);
    wr(5'h0B, 8'h00);
    wr(5'h0A, 8'h20);
    tk(16'h0020, 1'b0);
    rd(5'h05, 8'h02);
    tk(16'h0020, 1'b0);
    rd(5'h04, 8'h02);
    `CHK("pin", 3'h0, pin_level)
    wr(5'h03, 8'h02);
    `CHK("irq", 3'h2, irq_req)
    @(posedge clk) dir <= 3'h0;
    #1 `CHK("pin", 3'h7, pin_level)
    $display("misc done");
    test_done();
  end
endmodule
